// >>> verilog/spi_eeprom_defines.vh
`ifndef SPI_EEPROM_DEFINES_VH
`define SPI_EEPROM_DEFINES_VH
// ------------------------------------------------------------
// Instruction codes
// ------------------------------------------------------------
`define OP_SET_LATCH 8'h06
`define OP_CLR_LATCH 8'h04
`define OP_RD_STATUS 8'h05
`define OP_WR_STATUS 8'h01
`define OP_READ      8'h03
`define OP_WRITE     8'h02
`define OP_RD_IDPG   8'h83
`define OP_WR_IDPG   8'h82
`define OP_RD_LOCK   8'h87
`define OP_LOCK_IDPG 8'h86
// ------------------------------------------------------------
// Status byte layout and protection
// ------------------------------------------------------------
`define SR_WIP       0
`define SR_LATCH     1
`define SR_BP_LO     2
`define SR_BP_HI     3
`define SR_SRWD      7
`define BP_QUARTER   2'h1
`define BP_HALF      2'h2
`define BP_ALL       2'h3
// ------------------------------------------------------------
// Organisation and timing
// ------------------------------------------------------------
`define ADDR_BITS    15
`define PAGE_BITS    6
`define MEM_BYTES    32768
`define PAGE_BYTES   64
`define CLK_HZ       25000000
`define T_W_MS       4
`define T_W_CYCLES   ((`T_W_MS * `CLK_HZ) / 1000)
`endif

// >>> verilog/spi_byte_buffer.v
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer between the serial receiver and the command engine.
module spi_byte_buffer #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,    // System clock.
  input  wire             i_reset,  // Synchronous reset, active high.
  input  wire             i_valid,  // Fill side word valid.
  output wire             o_ready,  // Fill side may push.
  input  wire [WIDTH-1:0] i_data,   // Fill side word.
  output wire             o_valid,  // Drain side word valid.
  input  wire             i_ready,  // Drain side accepts.
  output wire [WIDTH-1:0] o_data    // Drain side word.
);
  reg [WIDTH-1:0] slot_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  // Full and empty come from the occupancy count, never from guesses.
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_data  = slot_q[rd_q];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // Pointers and count.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (push)
        wr_q <= ~wr_q;
      if (pop)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage needs no reset; the count guards stale words.
  always @(posedge i_clk)
  begin
    if (push)
      slot_q[wr_q] <= i_data;
  end
endmodule
`default_nettype wire

// >>> verilog/spi_eeprom_serial_interface.v
`include "spi_eeprom_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module spi_eeprom_serial_interface #(
  parameter T_W_CYCLES = `T_W_CYCLES,
  parameter TMR_BITS   = 17
) (
  input  wire i_clk,      // System clock, 25 MHz.
  input  wire i_reset,    // Synchronous reset, active high.
  input  wire i_sclk,     // Serial clock from the master.
  input  wire i_cs_n,     // Chip select, active low.
  input  wire i_mosi,     // Serial data in.
  input  wire i_hold_n,   // Pause, active low.
  input  wire i_wp_n,     // Status write protect, active low.
  output reg  o_miso,     // Serial data out.
  output reg  o_miso_oe,  // Output enable for serial data out.
  output reg  o_busy      // Programming cycle running.
);
  localparam [2:0] S_OP = 3'h0, S_AH = 3'h1, S_AL = 3'h2, S_WDATA = 3'h3;
  localparam [2:0] S_RDATA = 3'h4, S_SRDATA = 3'h5, S_SKIP = 3'h6;
  // ------------------------------------------------------------
  // Error correction helpers
  // ------------------------------------------------------------
  // Hamming check bits for one byte; syndrome gives the bad bit position.
  function [3:0] ecc_enc;
    input [7:0] d;
    begin
      ecc_enc[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      ecc_enc[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      ecc_enc[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      ecc_enc[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
    end
  endfunction
  function [7:0] ecc_fix;
    input [7:0] d;
    input [3:0] c;
    reg   [3:0] s;
    begin
      s = c ^ ecc_enc(d);
      ecc_fix = d;
      case (s)
        4'h3:    ecc_fix[0] = ~d[0];
        4'h5:    ecc_fix[1] = ~d[1];
        4'h6:    ecc_fix[2] = ~d[2];
        4'h7:    ecc_fix[3] = ~d[3];
        4'h9:    ecc_fix[4] = ~d[4];
        4'ha:    ecc_fix[5] = ~d[5];
        4'hb:    ecc_fix[6] = ~d[6];
        4'hc:    ecc_fix[7] = ~d[7];
        default: ecc_fix = d;
      endcase
    end
  endfunction
  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  // Bits: 0 clock, 1 select, 2 data, 3 pause, 4 protect.
  reg  [4:0] s1_q;
  reg  [4:0] s2_q;
  reg  [1:0] prev_q;
  wire sclk = s2_q[0];
  wire cs_n = s2_q[1];
  wire rise = sclk & ~prev_q[0];
  wire fall = ~sclk & prev_q[0];
  wire cs_fall = ~cs_n & prev_q[1];
  wire cs_rise = cs_n & ~prev_q[1];
  // Select and pause start low after reset, so a select held low through
  // reset is not taken until it has been high and falls again.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_q   <= 5'h00;
      s2_q   <= 5'h00;
      prev_q <= 2'h0;
    end
    else
    begin
      s1_q   <= {i_wp_n, i_hold_n, i_mosi, i_cs_n, i_sclk};
      s2_q   <= s1_q;
      prev_q <= s2_q[1:0];
    end
  end
  // ------------------------------------------------------------
  // Selection and pause
  // ------------------------------------------------------------
  reg  sel_q;
  reg  hold_q;
  wire act = sel_q & ~hold_q & ~cs_n;
  // Pause is entered and left only while the clock is low.
  always @(posedge i_clk)
  begin
    if (i_reset | cs_n)
    begin
      sel_q  <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      if (cs_fall)
        sel_q <= 1'b1;
      if (~sclk)
        hold_q <= ~s2_q[3];
    end
  end
  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  reg  [6:0] rx_sh_q;
  reg  [2:0] bit_cnt_q;
  reg        rxv_q;
  reg  [7:0] rxb_q;
  wire       f_in_ready;
  wire       f_valid;
  wire [7:0] f_data;
  reg        copy_q;
  wire       pop = f_valid & ~copy_q;
  // A full byte waits in rxv_q until the buffer takes it. Both clock idle
  // levels work since only rising edges inside a selection are counted.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_sh_q   <= 7'h00;
      bit_cnt_q <= 3'h0;
      rxv_q     <= 1'b0;
      rxb_q     <= 8'h00;
    end
    else
    begin
      if (rxv_q & f_in_ready)
        rxv_q <= 1'b0;
      if (~sel_q)
        bit_cnt_q <= 3'h0;
      else if (act & rise)
      begin
        rx_sh_q   <= {rx_sh_q[5:0], s2_q[2]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          rxv_q <= 1'b1;
          rxb_q <= {rx_sh_q, s2_q[2]};
        end
      end
    end
  end

  spi_byte_buffer #(.WIDTH(8)) u_rx_buf (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_valid (rxv_q),
    .o_ready (f_in_ready),
    .i_data  (rxb_q),
    .o_valid (f_valid),
    .i_ready (~copy_q),
    .o_data  (f_data)
  );
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg  [7:0]  mem_q  [0:`MEM_BYTES-1];
  reg  [3:0]  chk_q  [0:`MEM_BYTES-1];
  reg  [7:0]  id_q   [0:`PAGE_BYTES-1];
  reg  [7:0]  pbuf_q [0:`PAGE_BYTES-1];
  reg  [63:0] pval_q;
  reg  [2:0]  phase_q;
  reg  [7:0]  op_q;
  reg  [7:0]  wop_q;
  reg  [14:0] addr_q;
  reg  [5:0]  pcnt_q;
  wire [14:0] prog_addr = {addr_q[14:6], pcnt_q};
  wire        prog_we = copy_q & pval_q[pcnt_q];
  wire        buf_we = pop & (phase_q == S_WDATA)
                       & ((op_q == `OP_WRITE) | (op_q == `OP_WR_IDPG));
  // Page programming copies only the page offsets loaded since the last page copy, so a
  // partial page leaves the rest of the page untouched.
  always @(posedge i_clk)
  begin
    if (buf_we)
      pbuf_q[addr_q[5:0]] <= f_data;
    if (prog_we & (wop_q == `OP_WRITE))
    begin
      mem_q[prog_addr] <= pbuf_q[pcnt_q];
      chk_q[prog_addr] <= ecc_enc(pbuf_q[pcnt_q]);
    end
    if (prog_we & (wop_q == `OP_WR_IDPG))
      id_q[pcnt_q] <= pbuf_q[pcnt_q];
  end
  // ------------------------------------------------------------
  // Command engine, protection and output shifter
  // ------------------------------------------------------------
  reg                write_latch_flag_q;
  reg                wip_q;
  reg  [1:0]         bp_q;
  reg                srwd_q;
  reg                lock_q;
  reg  [7:0]         sr_new_q;
  reg                got_q;
  reg  [TMR_BITS-1:0] tmr_q;
  reg  [7:0]         tx_q;
  reg                tx_on_q;
  reg                ld_q;
  reg                started_q;
  reg  [2:0]         ocnt_q;
  reg  [7:0]         rd_byte;
  reg                wr_ok;
  wire [7:0] status = {srwd_q, 3'h0, bp_q, write_latch_flag_q, wip_q};
  wire       is_wr = (op_q == `OP_WRITE) | (op_q == `OP_WR_IDPG)
                     | (op_q == `OP_WR_STATUS) | (op_q == `OP_LOCK_IDPG);
  // Source of the next byte to send.
  always @*
  begin
    case (op_q)
      `OP_RD_STATUS: rd_byte = status;
      `OP_RD_LOCK:   rd_byte = {7'h00, lock_q};
      `OP_RD_IDPG:   rd_byte = id_q[addr_q[5:0]];
      default:       rd_byte = ecc_fix(mem_q[addr_q], chk_q[addr_q]);
    endcase
  end
  // Whether the pending write may run under the current protection.
  always @*
  begin
    case (op_q)
      `OP_WRITE:     wr_ok = ~((bp_q == `BP_ALL)
                             | ((bp_q == `BP_HALF) & addr_q[14])
                             | ((bp_q == `BP_QUARTER) & (addr_q[14:13] == 2'h3)));
      `OP_WR_STATUS: wr_ok = ~(srwd_q & ~s2_q[4]);
      default:       wr_ok = ~((bp_q == `BP_ALL) | lock_q);
    endcase
  end
  // Main sequencer. Deselect wins over a byte popped in the same cycle.
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      phase_q <= S_OP; op_q <= 8'h00; wop_q <= 8'h00; addr_q <= 15'h0000;
      write_latch_flag_q <= 1'b0; wip_q <= 1'b0; bp_q <= 2'h0; srwd_q <= 1'b0;
      lock_q <= 1'b0; sr_new_q <= 8'h00; got_q <= 1'b0; tmr_q <= {TMR_BITS{1'b0}};
      copy_q <= 1'b0; pcnt_q <= 6'h00; pval_q <= 64'h0;
      tx_q <= 8'h00; tx_on_q <= 1'b0; ld_q <= 1'b0; started_q <= 1'b0;
      ocnt_q <= 3'h0; o_miso <= 1'b0; o_miso_oe <= 1'b0; o_busy <= 1'b0;
    end
    else
    begin
      o_busy <= wip_q;
      ld_q   <= 1'b0;
      // The programming timer clears busy and the latch when it expires.
      if (wip_q)
      begin
        tmr_q <= tmr_q + {{(TMR_BITS-1){1'b0}}, 1'b1};
        if (tmr_q == T_W_CYCLES - 1)
        begin
          wip_q <= 1'b0;
          write_latch_flag_q <= 1'b0;
        end
      end
      if (copy_q)
      begin
        pcnt_q <= pcnt_q + 6'h01;
        if (pcnt_q == 6'h3f)
        begin
          copy_q <= 1'b0;
          pval_q <= 64'h0;
        end
      end
      if (ld_q)
      begin
        tx_q    <= rd_byte;
        tx_on_q <= 1'b1;
      end
      // Output shifts after each falling edge so the master samples on rise.
      if (act & fall & tx_on_q)
      begin
        o_miso    <= tx_q[7];
        tx_q      <= {tx_q[6:0], 1'b0};
        started_q <= 1'b1;
        ocnt_q    <= ocnt_q + 3'h1;
        if (ocnt_q == 3'h7)
        begin
          ld_q <= 1'b1;
          if (op_q == `OP_RD_IDPG)
            addr_q[5:0] <= addr_q[5:0] + 6'h01;
          else
            addr_q <= addr_q + 15'h0001;
        end
      end
      o_miso_oe <= act & tx_on_q & (started_q | fall);
      if (cs_rise)
      begin
        phase_q <= S_OP; tx_on_q <= 1'b0; started_q <= 1'b0;
        ocnt_q <= 3'h0; got_q <= 1'b0;
        // Write runs only with the latch set, data present, on a boundary.
        if (is_wr & got_q & (bit_cnt_q == 3'h0) & write_latch_flag_q & wr_ok & ~wip_q)
        begin
          wip_q  <= 1'b1;
          tmr_q  <= {TMR_BITS{1'b0}};
          wop_q  <= op_q;
          pcnt_q <= 6'h00;
          copy_q <= (op_q == `OP_WRITE) | (op_q == `OP_WR_IDPG);
          if (op_q == `OP_LOCK_IDPG)
            lock_q <= 1'b1;
          if (op_q == `OP_WR_STATUS)
          begin
            bp_q   <= sr_new_q[`SR_BP_HI:`SR_BP_LO];
            srwd_q <= sr_new_q[`SR_SRWD];
          end
        end
      end
      else if (pop)
      begin
        case (phase_q)
          S_OP:
          begin
            op_q <= f_data;
            phase_q <= S_SKIP;
            if (~wip_q | (f_data == `OP_RD_STATUS))
            begin
              case (f_data)
                `OP_SET_LATCH: write_latch_flag_q <= 1'b1;
                `OP_CLR_LATCH: write_latch_flag_q <= 1'b0;
                `OP_RD_STATUS: begin phase_q <= S_RDATA; ld_q <= 1'b1; end
                `OP_RD_LOCK:   begin phase_q <= S_RDATA; ld_q <= 1'b1; end
                `OP_WR_STATUS: phase_q <= S_SRDATA;
                `OP_READ, `OP_WRITE, `OP_RD_IDPG,
                `OP_WR_IDPG, `OP_LOCK_IDPG: phase_q <= S_AH;
                default:       phase_q <= S_SKIP;
              endcase
            end
          end
          S_AH:
          begin
            addr_q[14:8] <= f_data[6:0];
            phase_q      <= S_AL;
          end
          S_AL:
          begin
            addr_q[7:0] <= f_data;
            if (is_wr)
              phase_q <= S_WDATA;
            else
            begin
              phase_q <= S_RDATA;
              ld_q <= 1'b1;
            end
          end
          S_WDATA:
          begin
            got_q <= 1'b1;
            // Page write rolls over inside its own 64-byte page.
            if (buf_we)
            begin
              pval_q[addr_q[5:0]] <= 1'b1;
              addr_q[5:0]         <= addr_q[5:0] + 6'h01;
            end
          end
          S_SRDATA:
          begin
            sr_new_q <= f_data;
            got_q    <= 1'b1;
            phase_q  <= S_SKIP;
          end
          default: phase_q <= phase_q;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/spi_eeprom_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks on the serial front end.
module spi_eeprom_asserts #(
  parameter T_W_CYCLES = 200
) (
  input wire logic i_clk,     // Clock.
  input wire logic i_reset,   // Reset.
  input wire logic i_sclk,    // Link clock.
  input wire logic i_cs_n,    // Select.
  input wire logic i_hold_n,  // Pause.
  input wire logic o_miso,    // Data out.
  input wire logic o_miso_oe, // Drive enable.
  input wire logic o_busy     // Busy.
);
  logic        sclk_q;
  logic [3:0]  age_q;
  logic [17:0] blen_q;

  // Clocks since the last link clock fall, and length of the busy run.
  always_ff @(posedge i_clk)
  begin
    sclk_q <= i_sclk;
    blen_q <= o_busy ? blen_q + 18'h1 : 18'h0;
    if (i_reset)
      age_q <= 4'hf;
    else if (sclk_q && !i_sclk)
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_unsel;
    i_cs_n [*6];
  endsequence
  sequence s_paused;
    (!i_hold_n && !i_sclk) [*6];
  endsequence

  property p_unsel_float;
    s_unsel |-> !o_miso_oe;
  endproperty
  a_unsel_float: assert property (p_unsel_float)
    else $error("output driven while deselected");
  property p_pause_float;
    s_paused |-> !o_miso_oe;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("output driven while paused");
  property p_drive_cause;
    $rose(o_miso_oe) |-> !i_cs_n && i_hold_n;
  endproperty
  a_drive_cause: assert property (p_drive_cause)
    else $error("output enabled without a selection");
  property p_first_bit;
    $rose(o_miso_oe) && $past(i_hold_n, 8) |-> age_q inside {[1:5]};
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first bit not after a clock fall");
  property p_shift;
    o_miso_oe && $past(o_miso_oe) && $changed(o_miso) |-> age_q inside {[1:5]};
  endproperty
  a_shift: assert property (p_shift)
    else $error("output changed away from a clock fall");
  property p_busy_bound;
    o_busy |-> blen_q <= T_W_CYCLES;
  endproperty
  a_busy_bound: assert property (p_busy_bound)
    else $error("programming cycle too long");
  property p_busy_cause;
    $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("programming started while selected");
  property p_no_drop;
    $fell(o_miso_oe) |-> $past(i_cs_n, 2) || !$past(i_hold_n, 2);
  endproperty
  a_no_drop: assert property (p_no_drop)
    else $error("output released in mid read");
endmodule

bind spi_eeprom_serial_interface spi_eeprom_asserts #(.T_W_CYCLES(T_W_CYCLES)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .i_hold_n(i_hold_n), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_busy(o_busy));
`default_nettype wire

// >>> sim/spi_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// Bus master on the far side of the link.
module spi_master_model (
  input  wire logic i_clk,    // Bench clock.
  input  wire logic i_miso,   // Reply line.
  output var  logic o_sclk,   // Link clock.
  output var  logic o_cs_n,   // Select.
  output var  logic o_mosi,   // Data out.
  output var  logic o_hold_n  // Pause.
);
  logic cpol;

  // Idle levels at time zero.
  initial
  begin
    cpol = 1'b0;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_hold_n = 1'b1;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // The clock settles at its idle level before select falls.
  task automatic sel();
    @(posedge i_clk);
    o_sclk <= cpol;
    ticks(4);
    o_cs_n <= 1'b0;
    ticks(4);
  endtask

  // Data moves with the fall and is taken on the rise, top bit first; the reply
  // is sampled late because it crosses the device's synchronisers.
  task automatic xbyte(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      o_sclk <= 1'b0;
      o_mosi <= tx[i];
      ticks(4);
      o_sclk <= 1'b1;
      ticks(2);
      rx[i] = i_miso;
      ticks(2);
    end
  endtask

  // Deselect from the idle level; the data line is then let go and flips.
  task automatic desel();
    o_sclk <= cpol;
    ticks(4);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    ticks(8);
  endtask

  // Pause is entered and left only with the clock low.
  task automatic pause(input logic on);
    o_sclk <= 1'b0;
    ticks(2);
    o_hold_n <= ~on;
    ticks(8);
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_spi_eeprom_serial_interface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_eeprom_serial_interface;
  localparam int TW = 200;
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        i_wp_n = 1'b1;
  wire         sclk, cs_n, mosi, hold_n, miso, miso_oe, busy, q_line;
  logic [63:0] r;
  logic [15:0] busy_n;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;

  // A 40 ns clock.
  always #20 i_clk = ~i_clk;

  // The reply line has no pull, so a released line shows the inverse of the
  // last bit; a sample taken after the device lets go is then caught.
  assign q_line = miso_oe ? miso : ~miso;

  spi_eeprom_serial_interface #(.T_W_CYCLES(TW)) uut (
    .i_clk(i_clk), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
    .i_hold_n(hold_n), .i_wp_n(i_wp_n), .o_miso(miso), .o_miso_oe(miso_oe), .o_busy(busy));
  spi_master_model m (
    .i_clk(i_clk), .i_miso(q_line), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .o_hold_n(hold_n));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One selection of n bytes from the top of b, replies into r; an optional
  // pause comes before byte ph and the last byte may be cut short.
  task automatic frame(input logic [63:0] b, input int n, input int lb = 8, input int ph = 99);
    logic [7:0] rx;
    m.sel();
    for (int i = 0; i < n; i++)
    begin
      if (i == ph)
      begin
        m.pause(1'b1);
        check(miso_oe, 1'b0);
        m.pause(1'b0);
      end
      m.xbyte(b[63 - 8 * i -: 8], i == n - 1 ? lb : 8, rx);
      r = {r[55:0], rx};
    end
    m.desel();
  endtask

  task automatic rd_status();
    frame({8'h05, 56'h0}, 2);
  endtask

  // Counts the clocks for which the device stays busy.
  task automatic wait_prog();
    busy_n = 16'h0;
    while (busy === 1'b1 && busy_n < 2 * TW)
    begin
      @(posedge i_clk);
      busy_n++;
    end
  endtask

  task automatic prog(input logic [63:0] b, input int n);
    frame({8'h06, 56'h0}, 1);
    frame(b, n);
    wait_prog();
  endtask

  // Latch set and cleared by selections of their own.
  task automatic t_latch();
    rd_status();
    check(r[7:0], 8'h00);
    check(miso_oe, 1'b0);
    frame({8'h06, 56'h0}, 1);
    rd_status();
    check(r[7:0], 8'h02);
    frame({8'h04, 56'h0}, 1);
    rd_status();
    check(r[7:0], 8'h00);
  endtask

  // Writes without the latch, or cut inside a byte, start no cycle.
  task automatic t_refuse();
    frame(64'h0200105a00000000, 4);
    wait_prog();
    check(busy_n, 16'h0);
    frame({8'h06, 56'h0}, 1);
    frame(64'h0200105a00000000, 4, 4);
    wait_prog();
    check(busy_n, 16'h0);
  endtask

  // A page write past the page end, read back through a high address bit,
  // with a pause inside the read and then with the clock resting high.
  task automatic t_page();
    prog(64'h02003ea1b2c30000, 6);
    check(busy_n > TW / 2 && busy_n <= TW, 1'b1);
    rd_status();
    check(r[7:0], 8'h00);
    frame(64'h03803e0000000000, 5);
    check(r[15:0], 16'ha1b2);
    frame(64'h0300000000000000, 4);
    check(r[7:0], 8'hc3);
    frame(64'h03003e0000000000, 5, 8, 4);
    check(r[15:0], 16'ha1b2);
    m.cpol = 1'b1;
    frame(64'h03003e0000000000, 5);
    check(r[15:0], 16'ha1b2);
    m.cpol = 1'b0;
  endtask

  // Each protect size refuses its lowest address; the quarter and half sizes accept the one below.
  task automatic t_protect();
    logic [15:0] lo [3] = '{16'h6000, 16'h4000, 16'h0000};
    for (int k = 1; k < 4; k++)
    begin
      prog({8'h01, 4'h0, k[1:0], 2'h0, 48'h0}, 2);
      rd_status();
      check(r[7:0], {4'h0, k[1:0], 2'h0});
      prog({8'h02, lo[k - 1], 8'h66, 32'h0}, 4);
      check(busy_n, 16'h0);
      if (k < 3)
      begin
        prog({8'h02, lo[k - 1] - 16'h1, 8'h66, 32'h0}, 4);
        check(busy_n != 16'h0, 1'b1);
      end
    end
    // With the freeze bit set, a low protect pin holds the status byte.
    prog(64'h018c000000000000, 2);
    i_wp_n <= 1'b0;
    prog(64'h0100000000000000, 2);
    check(busy_n, 16'h0);
    rd_status();
    check(r[7:0], 8'h8e);
    i_wp_n <= 1'b1;
    prog(64'h0100000000000000, 2);
    rd_status();
    check(r[7:0], 8'h00);
  endtask

  // The extra page takes data until it is locked for good.
  task automatic t_id();
    frame({8'h06, 56'h0}, 1);
    frame(64'h8200057700000000, 4);
    rd_status();
    check(r[7:0], 8'h03);
    wait_prog();
    frame(64'h8300050000000000, 4);
    check(r[7:0], 8'h77);
    frame(64'h8700000000000000, 2);
    check(r[0], 1'b0);
    prog(64'h8600000000000000, 4);
    frame(64'h8700000000000000, 2);
    check(r[0], 1'b1);
    prog(64'h8200051100000000, 4);
    check(busy_n, 16'h0);
  endtask

  // Reset for two clocks, then each scenario in turn.
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
    t_latch();
    t_refuse();
    t_page();
    t_protect();
    t_id();
    test_done();
  end

  // Cut a hang short.
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      bad_count++;
      test_done();
    end
  end
endmodule
`default_nettype wire
